// *** wec_defines.svh ***
// Purpose: offsets, field positions and reset values of the wide event counter
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef WEC_DEFINES_SVH
`define WEC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define WEC_OFF_CTRL     12'h000
`define WEC_OFF_LOW      12'h004
`define WEC_OFF_HIGH     12'h008
`define WEC_OFF_FLAG     12'h00C
`define WEC_OFF_CMP1     12'h010
`define WEC_OFF_CMP2     12'h014
`define WEC_OFF_MODE     12'h018

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define WEC_CTRL_ON      0
`define WEC_CTRL_CS      1
`define WEC_CTRL_SYNCB   2
`define WEC_CTRL_OSCEN   3
`define WEC_CTRL_PS_LO   4
`define WEC_CTRL_RESET   8'h00

// ----------------------------------------------------------------------------
// flag and compare mode fields
// ----------------------------------------------------------------------------
`define WEC_FLAG_OVF     0
`define WEC_MODE_SPECIAL 4'hB
`define WEC_MODE_RESET   4'h0
`define WEC_CMP_RESET    16'h0000

`endif

// *** wec_pkg.sv ***
// Purpose: types of the wide event counter
// Assumes: nothing
// Notes:   constants live in wec_defines.svh
package wec_pkg;
  typedef enum logic [1:0] {
    WEC_SRC_INT,
    WEC_SRC_SYNC,
    WEC_SRC_ASYNC
  } wec_src_t;
endpackage

// *** wec_sync2.sv ***
// Purpose: two flip-flop level synchroniser
// Assumes: din comes from another clock domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module wec_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= din;
    dout   <= meta_q;
  end
endmodule

// *** wec_link_counter.sv ***
// Purpose: 16-bit count held in the link clock domain
// Assumes: load and clear requests arrive as toggles from the core domain
// Notes:   count keeps its value through every reset
`timescale 1ns/1ps
module wec_link_counter (
  input  wire logic        linkClk,
  input  wire logic        runAsync,
  input  wire logic        ldTgl,
  input  wire logic [15:0] ldVal,
  input  wire logic        clrTgl,
  output logic      [15:0] countGray,
  output logic             ovfTgl
);
  logic [1:0]  ldSync;
  logic [1:0]  clrSync;
  logic [1:0]  runSync;
  logic        ldSeen_q;
  logic        clrSeen_q;
  logic        ovfTgl_q;
  logic [15:0] count_q;
  logic        ldEv;
  logic        clrEv;

  wec_sync2 #(.W(2)) uSyncReq (
    .clk  (linkClk),
    .din  ({ldTgl, clrTgl}),
    .dout ({ldSync[0], clrSync[0]})
  );
  wec_sync2 #(.W(1)) uSyncRun (
    .clk  (linkClk),
    .din  (runAsync),
    .dout (runSync[0])
  );
  assign ldSync[1]  = 1'b0;
  assign clrSync[1] = 1'b0;
  assign runSync[1] = 1'b0;

  assign ldEv  = ldSync[0] ^ ldSeen_q;
  assign clrEv = clrSync[0] ^ clrSeen_q;

  always_ff @(posedge linkClk) begin
    ldSeen_q  <= ldSync[0];
    clrSeen_q <= clrSync[0];
  end

  // count runs on the link clock only, so it keeps going while the core sleeps
  // while stopped the count tracks the core's load value, so a start begins from it
  always_ff @(posedge linkClk) begin
    if (ldEv || !runSync[0]) begin
      count_q <= ldVal;
    end else if (clrEv) begin
      count_q <= 16'h0000;
    end else if (runSync[0]) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // toggle is parked low while stopped; the core ignores it then
  always_ff @(posedge linkClk) begin
    if (!runSync[0]) begin
      ovfTgl_q <= 1'b0;
    end else if (!ldEv && !clrEv && (count_q == 16'hFFFF)) begin
      ovfTgl_q <= ~ovfTgl_q;
    end
  end

  always_ff @(posedge linkClk) begin
    countGray <= count_q ^ (count_q >> 1);
  end

  assign ovfTgl = ovfTgl_q;
endmodule

// *** wec_wide_event_counter.sv ***
// Purpose: wide event counter with apb registers, prescaler and link-clock count
// Assumes: apb master on core_clk, external count clock on linkClk
// Notes:   count registers are not cleared by reset
//
// Overview of operation
// - sync bypass bit feeds raw link clock
// - unsynchronised counting continues while core sleeps
// - unsynchronised overflow raises wake interrupt request
// - unsynchronised count is not a compare time base
// - byte reads valid across clock domains
// - oscillator enable bit enables crystal oscillator
// - crystal oscillator keeps running during sleep
// - compare mode 1011 match resets count
// - special event reset never sets overflow flag
// - special event reset unguaranteed when unsynchronised
// - count write beats coincident special event reset
// - compare value acts as counter period
// - count bytes survive every reset
// - control clears only on power-on reset
// - count byte writes clear prescaler
`timescale 1ns/1ps
`include "wec_defines.svh"
module wec_wide_event_counter
  import wec_pkg::*;
#(
  parameter int PS_W = 3
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        powerOnReset,
  input  wire logic        linkClk,
  input  wire logic        extClkPin,
  input  wire logic        oscInputPin,
  input  wire logic        coreSleep,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             oscOutputPin,
  output logic             oscRunning,
  output logic             compareTimeBaseValid,
  output logic      [15:0] compareTimeBase,
  output logic             overflowIrq,
  output logic             wakeRequest
);

  // --------------------------------------------------------------------------
  // registers and nets
  // --------------------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic        flag_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic [3:0]  mode1_q;
  logic [3:0]  mode2_q;
  logic [15:0] cnt_q;
  logic [PS_W-1:0] ps_q;
  logic [2:0]  extSync;
  logic        extPrev_q;
  logic        ldTgl_q;
  logic [15:0] ldVal_q;
  logic        clrTgl_q;
  logic [15:0] ldBase;
  logic        aHit;
  logic        aHit_q;
  logic        aOvfEv;
  logic [15:0] aGray;
  logic [15:0] aGraySync;
  logic        aOvfTgl;
  logic        aOvfSync;
  logic        aOvfSeen_q;
  logic [15:0] aCount;
  logic        wrEn;
  logic        rdEn;
  logic        wrCnt;
  logic        tickRaw;
  logic        tick;
  logic        special;
  logic        wrapEv;
  wec_src_t    src;
  logic [PS_W-1:0] psMax;

  function automatic logic [15:0] grayToBin(input logic [15:0] g);
    logic [15:0] b;
    b = 16'h0000;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic hitsSpecial(input logic [3:0] mode, input logic [15:0] cmp,
                                       input logic [15:0] cnt);
    return (mode == `WEC_MODE_SPECIAL) && (cnt == cmp);
  endfunction

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  assign wrCnt   = wrEn && ((paddr == `WEC_OFF_LOW) || (paddr == `WEC_OFF_HIGH));

  // --------------------------------------------------------------------------
  // source selection and prescaler
  // --------------------------------------------------------------------------
  always_comb begin
    if (!ctrl_q[`WEC_CTRL_CS]) begin
      src = WEC_SRC_INT;
    end else if (ctrl_q[`WEC_CTRL_SYNCB]) begin
      src = WEC_SRC_ASYNC;
    end else begin
      src = WEC_SRC_SYNC;
    end
  end

  // external pin passes two flops, third flop for the edge detector
  wec_sync2 #(.W(1)) uSyncExt (
    .clk  (core_clk),
    .din  (ctrl_q[`WEC_CTRL_OSCEN] ? oscInputPin : extClkPin),
    .dout (extSync[0])
  );
  assign extSync[2:1] = 2'b00;

  always_ff @(posedge core_clk) begin
    extPrev_q <= extSync[0];
  end

  assign psMax   = PS_W'((1 << ctrl_q[`WEC_CTRL_PS_LO +: 2]) - 1);
  assign tickRaw = (src == WEC_SRC_INT) || (src == WEC_SRC_SYNC && extSync[0] && !extPrev_q);
  assign tick    = ctrl_q[`WEC_CTRL_ON] && tickRaw && (ps_q == psMax);

  always_ff @(posedge core_clk) begin
    if (wrCnt || !ctrl_q[`WEC_CTRL_ON]) begin
      ps_q <= '0;
    end else if (tickRaw) begin
      ps_q <= (ps_q == psMax) ? '0 : ps_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // crystal oscillator and sleep
  // --------------------------------------------------------------------------
  // inverting amplifier; sleep does not gate it
  assign oscOutputPin = ctrl_q[`WEC_CTRL_OSCEN] ? ~oscInputPin : 1'b0;
  assign oscRunning   = ctrl_q[`WEC_CTRL_OSCEN];

  // --------------------------------------------------------------------------
  // control, compare and mode registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (powerOnReset) begin
      ctrl_q <= `WEC_CTRL_RESET;
    end else if (wrEn && paddr == `WEC_OFF_CTRL) begin
      ctrl_q <= {2'b00, pwdata[5:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmp1_q  <= `WEC_CMP_RESET;
      cmp2_q  <= `WEC_CMP_RESET;
      mode1_q <= `WEC_MODE_RESET;
      mode2_q <= `WEC_MODE_RESET;
    end else if (wrEn) begin
      if (paddr == `WEC_OFF_CMP1) cmp1_q <= pwdata[15:0];
      if (paddr == `WEC_OFF_CMP2) cmp2_q <= pwdata[15:0];
      if (paddr == `WEC_OFF_MODE) begin
        mode1_q <= pwdata[3:0];
        mode2_q <= pwdata[7:4];
      end
    end
  end

  // --------------------------------------------------------------------------
  // synchronous count
  // --------------------------------------------------------------------------
  assign special = (src != WEC_SRC_ASYNC) &&
                   (hitsSpecial(mode1_q, cmp1_q, cnt_q) ||
                    hitsSpecial(mode2_q, cmp2_q, cnt_q));
  assign wrapEv  = tick && (cnt_q == 16'hFFFF) && !special && !wrCnt;

  // no reset branch: count survives every reset
  always_ff @(posedge core_clk) begin
    if (wrEn && paddr == `WEC_OFF_LOW) begin
      cnt_q[7:0] <= pwdata[7:0];
    end else if (wrEn && paddr == `WEC_OFF_HIGH) begin
      cnt_q[15:8] <= pwdata[7:0];
    end else if (special) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // link-clock count and crossing
  // --------------------------------------------------------------------------
  // load value follows the core count outside async mode, so back-to-back byte
  // writes compose from settled bytes rather than from the slow crossed count
  assign ldBase = (src == WEC_SRC_ASYNC) ? ldVal_q : cnt_q;

  always_ff @(posedge core_clk) begin
    if (wrCnt) begin
      ldVal_q <= (paddr == `WEC_OFF_LOW) ? {ldBase[15:8], pwdata[7:0]} :
                                           {pwdata[7:0], ldBase[7:0]};
    end else if (src != WEC_SRC_ASYNC) begin
      ldVal_q <= cnt_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (powerOnReset) begin
      ldTgl_q <= 1'b0;
    end else if (wrCnt) begin
      ldTgl_q <= ~ldTgl_q;
    end
  end

  // asynchronous special reset is best effort only, one request per match
  assign aHit = (src == WEC_SRC_ASYNC) &&
                (hitsSpecial(mode1_q, cmp1_q, aCount) || hitsSpecial(mode2_q, cmp2_q, aCount));

  always_ff @(posedge core_clk) begin
    aHit_q <= aHit;
  end

  always_ff @(posedge core_clk) begin
    if (powerOnReset) begin
      clrTgl_q <= 1'b0;
    end else if (!wrCnt && aHit && !aHit_q) begin
      clrTgl_q <= ~clrTgl_q;
    end
  end

  wec_link_counter uLink (
    .linkClk   (linkClk),
    .runAsync  (ctrl_q[`WEC_CTRL_ON] && src == WEC_SRC_ASYNC),
    .ldTgl     (ldTgl_q),
    .ldVal     (ldVal_q),
    .clrTgl    (clrTgl_q),
    .countGray (aGray),
    .ovfTgl    (aOvfTgl)
  );

  wec_sync2 #(.W(17)) uSyncCnt (
    .clk  (core_clk),
    .din  ({aOvfTgl, aGray}),
    .dout ({aOvfSync, aGraySync})
  );

  assign aCount = grayToBin(aGraySync);

  always_ff @(posedge core_clk) begin
    aOvfSeen_q <= aOvfSync;
  end

  // only a running async count may report an overflow
  assign aOvfEv = (aOvfSync ^ aOvfSeen_q) && (src == WEC_SRC_ASYNC) && ctrl_q[`WEC_CTRL_ON];

  // --------------------------------------------------------------------------
  // overflow flag, set wins over clear
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (wrapEv || aOvfEv) begin
      flag_q <= 1'b1;
    end else if (wrEn && paddr == `WEC_OFF_FLAG && !pwdata[`WEC_FLAG_OVF]) begin
      flag_q <= 1'b0;
    end
  end

  assign overflowIrq = flag_q;
  assign wakeRequest = flag_q && coreSleep;

  // --------------------------------------------------------------------------
  // compare time base
  // --------------------------------------------------------------------------
  assign compareTimeBaseValid = (src != WEC_SRC_ASYNC);
  assign compareTimeBase      = cnt_q;

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      unique case (paddr)
        `WEC_OFF_CTRL: prdata <= {24'h00_0000, ctrl_q};
        `WEC_OFF_LOW:  prdata <= {24'h00_0000, (src == WEC_SRC_ASYNC) ? aCount[7:0] : cnt_q[7:0]};
        `WEC_OFF_HIGH: prdata <= {24'h00_0000, (src == WEC_SRC_ASYNC) ? aCount[15:8] : cnt_q[15:8]};
        `WEC_OFF_FLAG: prdata <= {31'h0000_0000, flag_q};
        `WEC_OFF_CMP1: prdata <= {16'h0000, cmp1_q};
        `WEC_OFF_CMP2: prdata <= {16'h0000, cmp2_q};
        `WEC_OFF_MODE: prdata <= {24'h00_0000, mode2_q, mode1_q};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** wec_sva.sv ***
// Purpose: port assertions for the wide event counter
// Assumes: relations checked in the core clock domain only
// Notes:   bound to every counter instance
`timescale 1ns/1ps
`include "wec_defines.svh"
module wec_sva (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        powerOnReset,
  input wire logic        oscInputPin,
  input wire logic        coreSleep,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        oscOutputPin,
  input wire logic        oscRunning,
  input wire logic        compareTimeBaseValid,
  input wire logic [15:0] compareTimeBase,
  input wire logic        overflowIrq,
  input wire logic        wakeRequest
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence ctrlSetup;
    psel && !penable && !pwrite && paddr == `WEC_OFF_CTRL;
  endsequence
  sequence ctrlAccess;
    psel && penable;
  endsequence
  osc_follow_a: assert property (oscRunning |-> oscOutputPin == !oscInputPin)
    else $error("osc output does not invert osc input");
  osc_quiet_a: assert property (!oscRunning |-> !oscOutputPin)
    else $error("osc output driven while disabled");
  osc_hold_a: assert property (oscRunning && !powerOnReset &&
    !(psel && pwrite && paddr == `WEC_OFF_CTRL) |=> oscRunning)
    else $error("osc stopped without control write");
  ctrl_por_a: assert property (powerOnReset |=> !oscRunning)
    else $error("control not cleared by power-on reset");
  wake_req_a: assert property (overflowIrq && coreSleep |-> ##[0:1] wakeRequest)
    else $error("no wake request on overflow in sleep");
  wrap_flag_a: assert property (compareTimeBaseValid && $past(compareTimeBase) == 16'hFFFF
    && compareTimeBase == 16'h0000 |-> ##[0:2] overflowIrq)
    else $error("wrap did not set overflow flag");
  sev_noflag_a: assert property (compareTimeBaseValid && !overflowIrq &&
    $changed(compareTimeBase) && compareTimeBase == 16'h0000 &&
    $past(compareTimeBase) != 16'hFFFF |=> !overflowIrq [*2])
    else $error("count clear set overflow flag");
  ctrl_read_a: assert property (ctrlSetup ##1 ctrlAccess |->
    prdata[`WEC_CTRL_OSCEN] == oscRunning)
    else $error("control read disagrees with osc state");
endmodule

bind wec_wide_event_counter wec_sva u_sva (
  .core_clk, .reset, .powerOnReset, .oscInputPin, .coreSleep, .psel, .penable, .pwrite,
  .paddr, .prdata, .oscOutputPin, .oscRunning, .compareTimeBaseValid, .compareTimeBase,
  .overflowIrq, .wakeRequest
);

// *** wec_ext_clk_model.sv ***
// Purpose: external count clock and low-frequency crystal
// Assumes: free running, 160 ns period
// Notes:   phase offset keeps edges away from core edges
`timescale 1ns/1ps
module wec_ext_clk_model (
  output logic linkClk,
  output logic extClkPin,
  output logic oscInputPin
);
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #80 linkClk = ~linkClk;
  end
  assign extClkPin   = linkClk;
  assign oscInputPin = linkClk;
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the wide event counter
// Assumes: zero-wait apb slave, internal count at 1:1 prescale, 1:8 in the prescaler clear test
// Notes:   count is stopped before every count write except the low-byte write of the prescaler clear test
`timescale 1ns/1ps
`include "wec_defines.svh"
module tb;
  logic        core_clk = 1'b0, reset = 1'b1, powerOnReset = 1'b1, coreSleep = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r, hi;
  logic        pready, pslverr, oscOutputPin, oscRunning, compareTimeBaseValid;
  logic        overflowIrq, wakeRequest, linkClk, extClkPin, oscInputPin;
  logic [15:0] compareTimeBase, mx;
  int          num_errors = 0, n_checks = 0;

  always #2.5 core_clk = ~core_clk;

  wec_ext_clk_model u_wec_ext_clk_model (.linkClk, .extClkPin, .oscInputPin);
  wec_wide_event_counter #(.PS_W(3)) u_wec_wide_event_counter (
    .core_clk, .reset, .powerOnReset, .linkClk, .extClkPin, .oscInputPin, .coreSleep,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscOutputPin,
    .oscRunning, .compareTimeBaseValid, .compareTimeBase, .overflowIrq, .wakeRequest
  );

  // --------------------
  // bus and compare tasks
  // --------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(n, e, r[15:0]);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    results();
  end

  // --------------------
  // tests
  // --------------------
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    powerOnReset <= 1'b0;
    rd("ctrl", `WEC_OFF_CTRL, 16'h0000);
    rd("unmapped", 12'h100, 16'h0000);
    chk("no slverr", 16'h0000, {15'h0000, pslverr});
    wr(`WEC_OFF_LOW, 16'h0034);
    wr(`WEC_OFF_HIGH, 16'h0012);
    wr(`WEC_OFF_CTRL, 16'h0008);
    repeat (20) @(posedge core_clk);
    chk("osc on", 16'h0001, {15'h0000, oscRunning});
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    rd("ctrl kept", `WEC_OFF_CTRL, 16'h0008);
    rd("low kept", `WEC_OFF_LOW, 16'h0034);
    powerOnReset <= 1'b1;
    @(posedge core_clk);
    powerOnReset <= 1'b0;
    rd("ctrl por", `WEC_OFF_CTRL, 16'h0000);
    rd("high kept", `WEC_OFF_HIGH, 16'h0012);
    $display("test retain done");
    for (int u = 0; u < 2; u++) begin
      wr(`WEC_OFF_CTRL, 16'h0000);
      wr(`WEC_OFF_LOW, 16'h0000);
      wr(`WEC_OFF_HIGH, 16'h0000);
      wr(u ? `WEC_OFF_CMP2 : `WEC_OFF_CMP1, u ? 16'h0005 : 16'h0009);
      wr(`WEC_OFF_MODE, u ? 16'h00B0 : 16'h000B);
      wr(`WEC_OFF_CTRL, 16'h0001);
      mx = 16'h0000;
      repeat (60) begin
        @(negedge core_clk);
        if (compareTimeBase > mx) mx = compareTimeBase;
      end
      chk("period", u ? 16'h0005 : 16'h0009, mx);
    end
    rd("no ovf", `WEC_OFF_FLAG, 16'h0000);
    $display("test special event done");
    wr(`WEC_OFF_CTRL, 16'h0000);
    wr(`WEC_OFF_MODE, 16'h0000);
    wr(`WEC_OFF_LOW, 16'h00FF);
    wr(`WEC_OFF_HIGH, 16'h00FF);
    wr(`WEC_OFF_CTRL, 16'h0001);
    repeat (8) @(posedge core_clk);
    rd("wrap high", `WEC_OFF_HIGH, 16'h0000);
    rd("ovf set", `WEC_OFF_FLAG, 16'h0001);
    wr(`WEC_OFF_FLAG, 16'h0000);
    rd("ovf clear", `WEC_OFF_FLAG, 16'h0000);
    $display("test wrap done");
    wr(`WEC_OFF_CTRL, 16'h0000);
    wr(`WEC_OFF_CTRL, 16'h0031);
    repeat (4) @(posedge core_clk);
    wr(`WEC_OFF_LOW, 16'h0000);
    rd("ps cleared", `WEC_OFF_LOW, 16'h0000);
    repeat (15) @(posedge core_clk);
    rd("ps rate", `WEC_OFF_LOW, 16'h0002);
    wr(`WEC_OFF_CTRL, 16'h0000);
    wr(`WEC_OFF_CMP1, 16'h0000);
    wr(`WEC_OFF_MODE, 16'h000B);
    wr(`WEC_OFF_HIGH, 16'h0000);
    wr(`WEC_OFF_LOW, 16'h0000);
    wr(`WEC_OFF_LOW, 16'h0077);
    rd("write wins", `WEC_OFF_LOW, 16'h0077);
    wr(`WEC_OFF_MODE, 16'h0000);
    wr(`WEC_OFF_LOW, 16'h0000);
    wr(`WEC_OFF_CTRL, 16'h0003);
    repeat (200) @(posedge core_clk);
    chk("sync valid", 16'h0001, {15'h0000, compareTimeBaseValid});
    apb(1'b0, `WEC_OFF_LOW, 16'h0000);
    chk("sync moved", 16'h0001, {15'h0000, r[7:0] >= 8'h05 && r[7:0] <= 8'h07});
    $display("test prescale priority sync done");
    wr(`WEC_OFF_CTRL, 16'h0000);
    wr(`WEC_OFF_LOW, 16'h00F0);
    wr(`WEC_OFF_HIGH, 16'h00FF);
    wr(`WEC_OFF_CTRL, 16'h0007);
    coreSleep <= 1'b1;
    repeat (400) @(posedge core_clk);
    chk("base valid", 16'h0000, {15'h0000, compareTimeBaseValid});
    apb(1'b0, `WEC_OFF_HIGH, 16'h0000);
    hi = r;
    apb(1'b0, `WEC_OFF_LOW, 16'h0000);
    mx = r[15:0];
    apb(1'b0, `WEC_OFF_HIGH, 16'h0000);
    if (r[7:0] !== hi[7:0]) begin
      hi = r;
      apb(1'b0, `WEC_OFF_LOW, 16'h0000);
      mx = r[15:0];
    end
    chk("async high", 16'h00FF, hi[15:0]);
    chk("async moved", 16'h0001, {15'h0000, mx[7:0] > 8'hF0});
    repeat (600) @(posedge core_clk);
    chk("async ovf", 16'h0001, {15'h0000, overflowIrq});
    chk("wake", 16'h0001, {15'h0000, wakeRequest});
    $display("test async done");
    results();
  end
endmodule
